/* hw/wdtc_pkg.sv */
// Purpose: Shared constants and types of the watchdog timer block
// Assumes: 100 MHz system clock; 8-bit register port
// Notes:   Offsets are byte addresses on the plain register port

package wdtc_pkg;

    // ************************************************************
    // Clocking
    // ************************************************************
    localparam int unsigned CLK_HZ = 100_000_000;
    // Nominal watchdog oscillator rate
    localparam int unsigned OSC_HZ = 400_000;
    localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
    // Peripheral clock is the CPU clock halved
    localparam int unsigned PCLK_DIV = 2;
    // Ticks of each clock spent by the switch synchroniser
    localparam logic [1:0] SYNC_TICKS = 2'h2;

    // ************************************************************
    // Counter geometry
    // ************************************************************
    localparam int unsigned PRE_BASE = 5;
    localparam int PRE_W = 12;
    localparam logic [PRE_W-1:0] PRES_ALL = 12'hFFF;
    localparam logic [2:0] TAP_MAX = 3'h7;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] A_CTRL = 8'hA7;
    localparam logic [7:0] A_RELOAD = 8'hC1;
    localparam logic [7:0] A_FEED = 8'hC2;
    localparam logic [7:0] A_COUNT = 8'hC3;

    // Control register fields
    localparam int CB_SEL = 0;
    localparam int CB_FLAG = 1;
    localparam int CB_RUN = 2;
    localparam int CB_TAP = 5;

    // Reset values
    localparam logic [2:0] TAP_RST = 3'h7;
    localparam logic RUN_RST = 1'b1;
    localparam logic SEL_RST = 1'b1;
    localparam logic [7:0] RELOAD_RST = 8'hFF;

    // Feed sequence keys
    localparam logic [7:0] FEED_KEY1 = 8'hA5;
    localparam logic [7:0] FEED_KEY2 = 8'h5A;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        SW_IDLE,
        SW_RELEASE,
        SW_ACQUIRE
    } wdtc_sw_t;

endpackage : wdtc_pkg

/* hw/wdtc_tickgen.sv */
// Purpose: Divides the system clock into one-cycle tick pulses
// Assumes: Enable low models a stopped source clock
// Notes:   Count restarts from zero when the source is stopped

`timescale 1ns/100ps
`default_nettype none

module wdtc_tickgen import wdtc_pkg::*; #(
    parameter int unsigned DIV = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Source control
    input wire logic en,
    output logic tick
);

    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } wdtc_tg_t;

    wdtc_tg_t st_r;
    wdtc_tg_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!en) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == LAST) begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

    // A stopped source delivers nothing after its last tick
    tick_needs_en_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        ce && !en |=> !tick)
        else $error("tick after source stopped");

endmodule : wdtc_tickgen

`default_nettype wire

/* hw/wdtc_clksw.sv */
// Purpose: Glitch-free switch between peripheral and oscillator ticks
// Assumes: Start pulses only on a completed feed
// Notes:   A start during a switch is ignored

`timescale 1ns/100ps
`default_nettype none

module wdtc_clksw import wdtc_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Source ticks
    input wire logic pclk_tick,
    input wire logic osc_tick,
    // Selection
    input wire logic start,
    input wire logic target,
    output logic sel_osc,
    output logic switching,
    output logic wd_tick
);

    typedef struct packed {
        wdtc_sw_t state;
        logic [1:0] cnt;
        logic sel;
        logic tgt;
    } wdtc_csw_t;

    wdtc_csw_t st_r;
    wdtc_csw_t st_nxt;
    logic old_tick;
    logic new_tick;

    assign old_tick = st_r.sel ? osc_tick : pclk_tick;
    assign new_tick = st_r.tgt ? osc_tick : pclk_tick;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r.state)
            SW_IDLE: begin
                if (start && (target != st_r.sel)) begin
                    st_nxt.state = SW_RELEASE;
                    st_nxt.tgt = target;
                    st_nxt.cnt = 2'h0;
                end
            end
            // Stalls until restart if the old peripheral clock has stopped
            SW_RELEASE: begin
                if (old_tick) begin
                    st_nxt.cnt = st_r.cnt + 2'h1;
                    if (st_r.cnt == SYNC_TICKS - 2'h1) begin
                        st_nxt.state = SW_ACQUIRE;
                        st_nxt.cnt = 2'h0;
                    end
                end
            end
            SW_ACQUIRE: begin
                if (new_tick) begin
                    st_nxt.cnt = st_r.cnt + 2'h1;
                    if (st_r.cnt == SYNC_TICKS - 2'h1) begin
                        st_nxt.state = SW_IDLE;
                        st_nxt.sel = st_r.tgt;
                        st_nxt.cnt = 2'h0;
                    end
                end
            end
            default: st_nxt.state = SW_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r <= '{SW_IDLE, 2'h0, SEL_RST, SEL_RST};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign sel_osc = st_r.sel;
    assign switching = (st_r.state != SW_IDLE);
    // No counter ticks while neither source is attached
    assign wd_tick = !switching && old_tick;

    sel_only_idle_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        ce && start && (target != sel_osc) && !switching
            |=> switching && !wd_tick)
        else $error("switch did not detach the counter");

endmodule : wdtc_clksw

`default_nettype wire

/* hw/wdtc_top.sv */
// Purpose: Watchdog timer with prescaler, 8-bit down counter, two modes
// Assumes: Register port strobes are one cycle; clk_sys is the CPU clock
// Notes:   Oscillator and peripheral clocks are modelled as ticks
// Contract
// - Counter clock is the 400 kHz oscillator or peripheral clock.
// - New clock select takes effect only after a valid feed.
// - Switch waits two old-clock then two new-clock ticks.
// - Prescaler restarts at feed; switch may skew its count.
// - Stopped peripheral clock blocks oscillator selection until restart.
// - Watchdog mode: software feeds; running out resets the CPU.
// - Timer mode: control writes reach shadow one watchdog tick later.
// - Timer mode: underflow sets flag, interrupts if enabled.
// - Timer mode: flag clears only by software writing zero.
// - Timer mode: underflow reloads counter and keeps counting.
// - Valid feed loads reload value into counter.
// - Timer mode: wrong feed sequences are silently ignored.
// - Power down: oscillator runs only while selected.
// - Underflow during power down wakes the device.
// - Timeout is 2^(5+tap)*(reload+1)+1 watchdog clocks.
// - Run bit starts/stops; forced on with both safety bits set.
// - Watchdog mode: underflow sets flag; feed or zero write clears.

`timescale 1ns/100ps
`default_nettype none

module wdtc_top import wdtc_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Mode and system inputs
    input wire logic watchdog_mode_enable,
    input wire logic safety_enable,
    input wire logic watchdog_interrupt_enable,
    input wire logic power_down,
    input wire logic wdt_reset_cause,
    // Outputs to the system
    output logic cpu_reset_req,
    output logic irq_req,
    output logic wakeup
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic init;
        logic [2:0] tap;
        logic run;
        logic sel;
        logic flag;
        logic [7:0] reload;
        logic [2:0] sh_tap;
        logic sh_run;
        logic sh_pend;
        logic [PRE_W-1:0] pres;
        logic [7:0] cnt;
        logic uf_arm;
        logic feed_arm;
        logic [7:0] rdata;
        logic rst_req;
        logic wake;
    } wdtc_st_t;

    wdtc_st_t st_r;
    wdtc_st_t st_nxt;

    logic safe_lock;
    logic run_eff;
    logic sel_eff;
    logic wr_ctrl;
    logic wr_feed;
    logic good_feed;
    logic bad_feed;
    logic flag_clr;
    logic uf;
    logic [PRE_W-1:0] pmask;
    logic pclk_tick;
    logic osc_tick;
    logic sel_osc;
    logic switching;
    logic wd_tick;

    // ************************************************************
    // Clock sources
    // ************************************************************
    // The CPU clock, and so the peripheral clock, stops in power down
    wdtc_tickgen #(.DIV(PCLK_DIV)) u_pclk (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .en(!power_down),
        .tick(pclk_tick)
    );

    // Oscillator survives power down only when it clocks the counter
    wdtc_tickgen #(.DIV(OSC_DIV)) u_osc (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .en(!power_down || sel_osc),
        .tick(osc_tick)
    );

    wdtc_clksw u_sw (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .pclk_tick(pclk_tick),
        .osc_tick(osc_tick),
        .start(good_feed),
        .target(sel_eff),
        .sel_osc(sel_osc),
        .switching(switching),
        .wd_tick(wd_tick)
    );

    // ************************************************************
    // Decode
    // ************************************************************
    assign safe_lock = watchdog_mode_enable && safety_enable;
    assign run_eff = st_r.sh_run || safe_lock;
    assign sel_eff = st_r.sel || safe_lock;
    assign wr_ctrl = wr && (addr == A_CTRL);
    assign wr_feed = wr && (addr == A_FEED);
    // Key two must be the very next write after key one
    assign good_feed = wr_feed && st_r.feed_arm
        && (wdata == FEED_KEY2);
    assign bad_feed = wr && !good_feed
        && (st_r.feed_arm || (wr_feed && wdata != FEED_KEY1));
    assign flag_clr = wr_ctrl && !wdata[CB_FLAG];
    assign uf = wd_tick && run_eff && st_r.uf_arm;
    // Tap selects a period of 2^(5+tap) ticks
    assign pmask = PRES_ALL >> (TAP_MAX - st_r.sh_tap);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rst_req = 1'b0;
        st_nxt.wake = 1'b0;
        st_nxt.rdata = 8'h00;
        st_nxt.init = 1'b1;

        // Feed sequencer
        if (wr) begin
            st_nxt.feed_arm = wr_feed && !st_r.feed_arm
                && (wdata == FEED_KEY1);
        end

        // Register writes
        if (wr_ctrl) begin
            st_nxt.tap = wdata[CB_TAP +: 3];
            st_nxt.run = wdata[CB_RUN];
            st_nxt.sel = wdata[CB_SEL];
            st_nxt.sh_pend = 1'b1;
        end
        if (wr && addr == A_RELOAD) begin
            st_nxt.reload = wdata;
        end

        // Timer mode copies control into the shadow on the next tick
        if (!watchdog_mode_enable && st_r.sh_pend && wd_tick) begin
            st_nxt.sh_tap = st_r.tap;
            st_nxt.sh_run = st_r.run;
            st_nxt.sh_pend = wr_ctrl;
        end

        // Counting; prescaler then down counter, one extra tick at end
        if (wd_tick && run_eff) begin
            if (st_r.uf_arm) begin
                st_nxt.uf_arm = 1'b0;
            end else if (st_r.pres >= pmask) begin
                st_nxt.pres = '0;
                if (st_r.cnt == 8'h00) begin
                    st_nxt.uf_arm = 1'b1;
                end else begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end
            end else begin
                st_nxt.pres = st_r.pres + PRE_W'(1);
            end
        end

        if (uf) begin
            st_nxt.wake = power_down;
            if (watchdog_mode_enable) begin
                st_nxt.rst_req = 1'b1;
            end else begin
                st_nxt.cnt = st_r.reload;
                st_nxt.pres = '0;
            end
        end

        // Watchdog mode: a broken sequence is as bad as running out
        if (bad_feed && watchdog_mode_enable && run_eff) begin
            st_nxt.rst_req = 1'b1;
        end

        // Feed reloads, restarts prescaler and commits the shadow
        if (good_feed) begin
            st_nxt.cnt = st_r.reload;
            st_nxt.pres = '0;
            st_nxt.uf_arm = 1'b0;
            st_nxt.sh_tap = st_r.tap;
            st_nxt.sh_run = st_r.run;
            st_nxt.sh_pend = 1'b0;
        end

        // Flag: set wins over any clear in the same cycle
        if (!st_r.init) begin
            st_nxt.flag = wdt_reset_cause;
        end else if (uf) begin
            st_nxt.flag = 1'b1;
        end else if (flag_clr) begin
            st_nxt.flag = 1'b0;
        end else if (good_feed && watchdog_mode_enable) begin
            st_nxt.flag = 1'b0;
        end

        // Read data appears the cycle after the strobe
        if (rd) begin
            unique case (addr)
                A_CTRL: st_nxt.rdata = {st_r.tap, 2'b00, run_eff,
                    st_r.flag, sel_eff};
                A_RELOAD: st_nxt.rdata = st_r.reload;
                A_COUNT: st_nxt.rdata = st_r.cnt;
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r <= '{
                init: 1'b0,
                tap: TAP_RST,
                run: RUN_RST,
                sel: SEL_RST,
                flag: 1'b0,
                reload: RELOAD_RST,
                sh_tap: TAP_RST,
                sh_run: RUN_RST,
                sh_pend: 1'b0,
                pres: '0,
                cnt: RELOAD_RST,
                uf_arm: 1'b0,
                feed_arm: 1'b0,
                rdata: 8'h00,
                rst_req: 1'b0,
                wake: 1'b0
            };
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign cpu_reset_req = st_r.rst_req;
    assign wakeup = st_r.wake;
    assign irq_req = st_r.flag && watchdog_interrupt_enable
        && !watchdog_mode_enable;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    feed_reload_a: assert property (
        ce && good_feed |=> st_r.cnt == $past(st_r.reload)
            && st_r.pres == '0)
        else $error("feed did not reload counter");

    timer_reload_a: assert property (
        ce && uf && !watchdog_mode_enable && !good_feed
            |=> st_r.cnt == $past(st_r.reload) && !cpu_reset_req)
        else $error("timer underflow did not reload");

    underflow_flag_a: assert property (
        ce && uf |=> st_r.flag)
        else $error("underflow did not set flag");

    flag_hold_a: assert property (
        st_r.flag && !watchdog_mode_enable && !flag_clr && st_r.init
            |=> st_r.flag)
        else $error("flag cleared without software");

    wdog_reset_a: assert property (
        ce && uf && watchdog_mode_enable |=> cpu_reset_req ##1
            (!cpu_reset_req || $past(!ce || uf || bad_feed, 1)))
        else $error("underflow did not reset cpu");

    bad_feed_quiet_a: assert property (
        ce && bad_feed && !watchdog_mode_enable && !wd_tick
            |=> !cpu_reset_req && $stable(st_r.cnt))
        else $error("wrong feed acted in timer mode");

    irq_follow_a: assert property (
        ce && uf && !watchdog_mode_enable && watchdog_interrupt_enable
            ##1 watchdog_interrupt_enable && !watchdog_mode_enable
            |-> irq_req)
        else $error("no interrupt on timer underflow");

    safety_lock_a: assert property (
        ce && safe_lock && wd_tick && !good_feed && !st_r.uf_arm
            |=> $changed(st_r.pres)) else $error("safety lock not running");

    wake_pd_a: assert property (
        ce && uf && power_down |=> wakeup)
        else $error("no wakeup on underflow");

    sel_on_feed_a: assert property (
        ce && wr_ctrl && !switching && sel_osc != wdata[CB_SEL]
            && !safe_lock |=> !switching)
        else $error("clock switched without feed");

endmodule : wdtc_top

`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for the watchdog timer block
// Assumes: Register map and feed keys of wdtc_pkg; ce held high
// Notes:   Peripheral tick every 2 cycles, oscillator tick every 250

`timescale 1ns/100ps
`default_nettype none

module tb import wdtc_pkg::*;;
    // ************************************************************
    // Clock, reset and design
    // ************************************************************
    logic clk_sys, rstn, ce, wr, rd, wme, se, wie, pd, cause;
    logic [7:0] addr, wdata, rdata, v, c1;
    logic cpu_reset_req, irq_req, wakeup;
    int n_fail, n_checks, cyc, rst_cnt, wk_cnt, t1, n, rc, wk;

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    wdtc_top u_wdtc_top (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .watchdog_mode_enable(wme), .safety_enable(se),
        .watchdog_interrupt_enable(wie), .power_down(pd),
        .wdt_reset_cause(cause), .cpu_reset_req(cpu_reset_req),
        .irq_req(irq_req), .wakeup(wakeup)
    );

    // Pulse counters and hang guard; the ceiling is a few times the plan
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cpu_reset_req === 1'b1) rst_cnt <= rst_cnt + 1;
        if (wakeup === 1'b1) wk_cnt <= wk_cnt + 1;
        if (cyc == 40000) begin
            n_fail = n_fail + 1;
            end_of_test();
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // Both key writes back to back, as one feed
    task automatic feed();
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= A_FEED;
        wdata <= FEED_KEY1;
        @(posedge clk_sys);
        wdata <= FEED_KEY2;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : feed

    task automatic wait_irq(input int lim, output int k);
        k = 0;
        while (irq_req !== 1'b1 && k < lim) begin
            step(1);
            k = k + 1;
        end
        chk(k < lim, 1'b1);
    endtask : wait_irq

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {rstn, wr, rd, wme, se, wie, pd, cause} = 8'h00;
        ce = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        {n_fail, n_checks, cyc, rst_cnt, wk_cnt} = '0;
        step(16);
        rstn <= 1'b1;
        step(2);
        rd_reg(A_CTRL, v);
        chk(v, {TAP_RST, 2'b00, RUN_RST, 1'b0, SEL_RST});
        rd_reg(A_RELOAD, v);
        chk(v, RELOAD_RST);
        rd_reg(A_COUNT, v);
        chk(v, 8'hFF);
        rd_reg(A_FEED, v);
        chk(v, 8'h00);
        rd_reg(8'h10, v);
        chk(v, 8'h00);
        $display("test reset done");

        // Timer mode, tap 0, reload 0, peripheral clock
        wie <= 1'b1;
        wr_reg(A_RELOAD, 8'h00);
        wr_reg(A_CTRL, 8'h04);
        // Long enough for a premature switch to have finished
        step(600);
        chk(irq_req, 1'b0);
        feed();
        wait_irq(900, n);
        chk(n > OSC_DIV, 1'b1);
        t1 = cyc;
        wr_reg(A_CTRL, 8'h06);
        step(1);
        chk(irq_req, 1'b1);
        rd_reg(A_CTRL, v);
        chk(v[CB_FLAG], 1'b1);
        wr_reg(A_CTRL, 8'h04);
        step(1);
        chk(irq_req, 1'b0);
        wait_irq(100, n);
        chk((cyc - t1) >= 62 && (cyc - t1) <= 70, 1'b1);
        $display("test timer period done");

        wie <= 1'b0;
        wr_reg(A_CTRL, 8'h04);
        step(90);
        rd_reg(A_CTRL, v);
        chk({v[CB_FLAG], irq_req}, 2'b10);
        wie <= 1'b1;
        step(1);
        chk(irq_req, 1'b1);
        rc = rst_cnt;
        wr_reg(A_FEED, FEED_KEY1);
        wr_reg(A_RELOAD, 8'h00);
        wr_reg(A_FEED, 8'h11);
        step(3);
        chk(rst_cnt, rc);
        $display("test timer feeds done");

        wr_reg(A_RELOAD, 8'h40);
        feed();
        wr_reg(A_CTRL, 8'h00);
        step(10);
        rd_reg(A_COUNT, c1);
        chk(c1, 8'h40);
        step(100);
        rd_reg(A_COUNT, v);
        chk(v, c1);
        wr_reg(A_RELOAD, 8'h00);
        wr_reg(A_CTRL, 8'h04);
        feed();
        $display("test run control done");

        // Watchdog mode: running out asks for a CPU reset
        wme <= 1'b1;
        feed();
        rc = rst_cnt;
        n = 0;
        while (rst_cnt == rc && n < 100) begin
            step(1);
            n = n + 1;
        end
        chk(n >= 62 && n < 100, 1'b1);
        rd_reg(A_CTRL, v);
        chk(v[CB_FLAG], 1'b1);
        feed();
        rd_reg(A_CTRL, v);
        chk(v[CB_FLAG], 1'b0);
        rc = rst_cnt;
        wr_reg(A_FEED, FEED_KEY1);
        wr_reg(A_FEED, 8'h00);
        step(2);
        chk(rst_cnt, rc + 1);
        se <= 1'b1;
        wr_reg(A_CTRL, 8'h00);
        rd_reg(A_CTRL, v);
        chk(v & 8'h05, 8'h05);
        se <= 1'b0;
        wme <= 1'b0;
        $display("test watchdog mode done");

        // Power down: oscillator keeps counting, peripheral clock stops
        wr_reg(A_CTRL, 8'h05);
        feed();
        step(600);
        pd <= 1'b1;
        wk = wk_cnt;
        n = 0;
        while (wk_cnt == wk && n < 9500) begin
            step(1);
            n = n + 1;
        end
        chk(wk_cnt, wk + 1);
        pd <= 1'b0;
        wr_reg(A_CTRL, 8'h04);
        feed();
        step(600);
        pd <= 1'b1;
        // Let a tick already in flight settle, then clear the flag
        step(3);
        wr_reg(A_CTRL, 8'h04);
        wk = wk_cnt;
        rd_reg(A_CTRL, c1);
        step(300);
        rd_reg(A_CTRL, v);
        chk(v, c1);
        chk(wk_cnt, wk);
        pd <= 1'b0;
        $display("test power down done");
        end_of_test();
    end
endmodule : tb

`default_nettype wire
